/* smc_pkg.sv */
package smc_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam real AN_T0_MS = 1.6;
	localparam real AN_T1_US = 2.0;
	localparam real AN_T2_US = 800.0;
	localparam real AN_T3_MS = 11.0;
	localparam int AN_CYC0 = int'(AN_T0_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int AN_CYC1 = int'(AN_T1_US * 1.0e3 / CLK_PERIOD_NS);
	localparam int AN_CYC2 = int'(AN_T2_US * 1.0e3 / CLK_PERIOD_NS);
	localparam int AN_CYC3 = int'(AN_T3_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int QUIET_BASE_US = 3100;
	localparam int QUIET_STEP_US = 100;
	localparam int QUIET_BASE_CYC = QUIET_BASE_US * 1000 / CLK_PERIOD_NS;
	localparam int QUIET_STEP_CYC = QUIET_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int TMR_W = 20;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam int AV_AW = 13;
	localparam logic [10:0] IDX_CTRL_ONE = 11'h608;
	localparam logic [10:0] IDX_TX_TIMERS = 11'h609;
	localparam logic [10:0] IDX_STATUS = 11'h60A;
	localparam logic [10:0] IDX_QUIET = 11'h60B;
	localparam logic [10:0] IDX_CTRL_TWO = 11'h60C;
	localparam logic [10:0] IDX_FIFO_ERR = 11'h60D;
	localparam logic [10:0] IDX_INT_STATUS = 11'h610;
	localparam logic [10:0] IDX_INT_MASK = 11'h611;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_CTRL_ONE = 16'h007B;
	localparam logic [15:0] RST_TX_TIMERS = 16'h0000;
	localparam logic [3:0] RST_QUIET = 4'h5;
	localparam logic [15:0] RST_CTRL_TWO = 16'h0024;
	localparam logic [2:0] STRAP_SGMII_ON = 3'h0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int C1_TXERR_DIS = 15;
	localparam int C1_FORCE_EN = 14;
	localparam int C1_IDX_LO = 10;
	localparam int C1_SGMII_EN = 9;
	localparam int C1_RX_POL = 8;
	localparam int C1_TX_POL = 7;
	localparam int C1_TX_ORD_LO = 5;
	localparam int C1_RX_ORD = 4;
	localparam int C1_ALIGN_PKT = 3;
	localparam int C1_AN_TMR_LO = 1;
	localparam int C1_AN_EN = 0;
	localparam int ST_PAGE = 12;
	localparam int ST_LINK = 11;
	localparam int ST_AN_DONE = 10;
	localparam int ST_ALIGN = 9;
	localparam int ST_SYNC = 8;
	localparam int ST_IDX_LO = 4;
	localparam int C2_LOCK_VAL = 8;
	localparam int C2_LOCK_FORCE = 7;
	localparam int C2_RESTART = 6;
	localparam int C2_TX_MID_LO = 3;
	localparam int C2_RX_MID_LO = 0;
	localparam int INT_W = 5;
	localparam int INT_PAGE = 0;
	localparam int INT_AN_DONE = 1;
	localparam int INT_LINK_CHG = 2;
	localparam int INT_FIFO = 3;
	localparam int INT_QUIET = 4;

	typedef enum {AN_OFF, AN_WAIT, AN_SETTLE, AN_DONE} smc_an_e;

endpackage

/* smc_an_timer.sv */
`timescale 1ns/1ps
module smc_an_timer import smc_pkg::*;
#(
	parameter int AN_CYCLES0 = AN_CYC0,
	parameter int AN_CYCLES1 = AN_CYC1,
	parameter int AN_CYCLES2 = AN_CYC2,
	parameter int AN_CYCLES3 = AN_CYC3
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic anEnable,
	input wire logic anRestart,
	input wire logic [1:0] timerSel,
	// Link events
	input wire logic pageIn,
	input wire logic syncOk,
	// Result
	output logic anComplete
);

	smc_an_e state_ff;
	smc_an_e nxt_state;
	logic [TMR_W-1:0] count_ff;
	logic [TMR_W-1:0] nxt_count;

	function automatic logic [TMR_W-1:0] loadValue(input logic [1:0] sel);
		unique case (sel)
			2'h0: loadValue = TMR_W'(AN_CYCLES0 - 1);
			2'h1: loadValue = TMR_W'(AN_CYCLES1 - 1);
			2'h2: loadValue = TMR_W'(AN_CYCLES2 - 1);
			2'h3: loadValue = TMR_W'(AN_CYCLES3 - 1);
		endcase
	endfunction

	always_comb
	begin
		nxt_state = state_ff;
		nxt_count = (count_ff != '0) ? count_ff - 1'b1 : count_ff;
		if (!anEnable)
			nxt_state = AN_OFF; // RL3
		else if (anRestart || state_ff == AN_OFF || (state_ff == AN_DONE && !syncOk))
		begin
			nxt_state = AN_WAIT;
			nxt_count = loadValue(timerSel); // RL2
		end
		else
		begin
			unique case (state_ff)
				AN_WAIT:
					if (pageIn)
					begin
						nxt_state = AN_SETTLE;
						nxt_count = loadValue(timerSel); // RL2
					end
					else if (count_ff == '0)
						nxt_count = loadValue(timerSel);
				AN_SETTLE:
					if (count_ff == '0)
						nxt_state = AN_DONE;
				AN_DONE:
					nxt_state = AN_DONE;
				AN_OFF:
					nxt_state = AN_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_ff <= AN_OFF;
			count_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
		end
	end

	assign anComplete = (state_ff == AN_DONE);

endmodule

/* smc_mac_ctrl.sv */
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// [RL1] Bit 9 enables the serial MAC interface; resets to 1 when straps read 000.
// [RL2] Two-bit code picks negotiation timer: 1.6ms, 2us, 800us or 11ms.
// [RL3] Negotiation runs only while enable bit 0 is set; it resets to 1.
// [RL4] Forced-alignment bit selects programmed index in bits 13-10 over search result.
// [RL5] Bit 8 inverts receive polarity, bit 7 transmit polarity; both reset 0.
// [RL6] Receive bit order: 0 gives MSB-first, 1 LSB-first; resets to 1.
// [RL7] Packet-alignment bit holds transmit packet start for the even code slot.
// [RL8] EEE control bit 0 enables support mode for a MAC without serial EEE.
// [RL9] Receive quiet timer is 3100 plus 100 times code microseconds; code resets 5.
// [RL10] Page-received bit 12 sets on a new page, clears when read.
// [RL11] Status bit 11 shows link up, bit 10 negotiation complete.
// [RL12] Word-boundary align, sync and index appear as read-only status bits.
// [RL13] Lock-override bit 7 substitutes bit 8 for the recovered lock.
// [RL14] Writing 1 to bit 6 restarts negotiation; writing 0 does nothing.
// [RL15] Two three-bit FIFO mid-level thresholds, each resetting to 4.
// [RL16] Hardware-set flags report receive and transmit FIFO full and empty errors.
// [RL17] Bit 15 suppresses transmit error signalling; resets to 0.
// [RL18] Restart bit clears itself one clock after it is set, at the same edge that negotiation restarts.
module smc_mac_ctrl import smc_pkg::*;
#(
	parameter int AN_CYCLES0 = AN_CYC0,
	parameter int AN_CYCLES2 = AN_CYC2,
	parameter int AN_CYCLES3 = AN_CYC3,
	parameter int QUIET_BASE_CYCLES = QUIET_BASE_CYC,
	parameter int QUIET_STEP_CYCLES = QUIET_STEP_CYC
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [AV_AW-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	// Straps
	input wire logic [2:0] rxDataStrap,
	// Datapath status
	input wire logic wbAligned,
	input wire logic wbSynced,
	input wire logic [3:0] wbIdx,
	input wire logic cdrLockRaw,
	input wire logic anPageIn,
	input wire logic rxLpiActive,
	input wire logic rxFifoOverErr,
	input wire logic rxFifoUnderErr,
	input wire logic txFifoOverErr,
	input wire logic txFifoUnderErr,
	input wire logic txPktReady,
	input wire logic txEvenSlot,
	// Datapath control
	output logic sgmiiEnable,
	output logic rxPolInvert,
	output logic txPolInvert,
	output logic rxLsbFirst,
	output logic [1:0] txBitOrder,
	output logic [3:0] alignIdx,
	output logic anEnable,
	output logic anRestart,
	output logic serialLinkUp,
	output logic cdrLock,
	output logic eeeNonEeeMode,
	output logic [4:0] txTrTimer,
	output logic [4:0] txTqTimer,
	output logic [4:0] txTsTimer,
	output logic rxQuietExpired,
	output logic txErrSuppress,
	output logic [2:0] txFifoMidLevel,
	output logic [2:0] rxFifoMidLevel,
	output logic txPktLaunch,
	// Interrupt
	output logic irq
);

	// ****************************************
	// Bus slave
	// ****************************************
	logic reqDone_ff;
	logic [31:0] rdData_ff;
	logic [15:0] ctrlOne_ff;
	logic [15:0] txTimers_ff;
	logic [3:0] quietCode_ff;
	logic [15:0] ctrlTwo_ff;
	logic pageRx_ff;
	logic [3:0] fifoErr_ff;
	logic [INT_W-1:0] intStatus_ff;
	logic [INT_W-1:0] intMask_ff;
	logic anComplete;
	logic linkUpRaw;
	logic linkUp_ff;
	logic anDone_ff;
	logic quietRun_ff;
	logic quietExp_ff;
	logic [TMR_W-1:0] quietCnt_ff;
	logic [10:0] regIdx;
	logic wrAcc;
	logic rdAcc;
	logic [15:0] statusWord;
	logic [INT_W-1:0] intEvents;

	assign regIdx = avsAddress[AV_AW-1:2];
	// One wait state lets read data come from a flop
	assign avsWaitRequest = (avsRead | avsWrite) & ~reqDone_ff;
	assign wrAcc = avsWrite & reqDone_ff;
	assign rdAcc = avsRead & reqDone_ff;
	assign avsReadData = rdData_ff;

	function automatic logic [15:0] beMerge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be);
		beMerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic [TMR_W-1:0] quietLoad(input logic [3:0] code);
		quietLoad = TMR_W'(QUIET_BASE_CYCLES + int'(code) * QUIET_STEP_CYCLES - 1); // RL9
	endfunction

	assign statusWord = {3'h0, pageRx_ff, linkUp_ff, anDone_ff, wbAligned, wbSynced,
		wbIdx, 4'h0}; // RL12

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			reqDone_ff <= 1'b0;
		else
			reqDone_ff <= (avsRead | avsWrite) & ~reqDone_ff;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdData_ff <= 32'h0000_0000;
		else if (avsRead && !reqDone_ff)
		begin
			unique case (regIdx)
				IDX_CTRL_ONE: rdData_ff <= {16'h0000, ctrlOne_ff};
				IDX_TX_TIMERS: rdData_ff <= {16'h0000, txTimers_ff};
				IDX_STATUS: rdData_ff <= {16'h0000, statusWord};
				IDX_QUIET: rdData_ff <= {28'h000_0000, quietCode_ff};
				IDX_CTRL_TWO: rdData_ff <= {16'h0000, ctrlTwo_ff};
				IDX_FIFO_ERR: rdData_ff <= {28'h000_0000, fifoErr_ff};
				IDX_INT_STATUS: rdData_ff <= {27'h000_0000, intStatus_ff};
				IDX_INT_MASK: rdData_ff <= {27'h000_0000, intMask_ff};
				default: rdData_ff <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrlOne_ff <= RST_CTRL_ONE;
			ctrlOne_ff[C1_SGMII_EN] <= (rxDataStrap == STRAP_SGMII_ON); // RL1
		end
		else if (wrAcc && regIdx == IDX_CTRL_ONE)
			ctrlOne_ff <= beMerge(ctrlOne_ff, avsWriteData[15:0], avsByteEnable[1:0]);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			txTimers_ff <= RST_TX_TIMERS;
		else if (wrAcc && regIdx == IDX_TX_TIMERS)
			txTimers_ff <= beMerge(txTimers_ff, avsWriteData[15:0], avsByteEnable[1:0]);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			quietCode_ff <= RST_QUIET; // RL9
		else if (wrAcc && regIdx == IDX_QUIET && avsByteEnable[0])
			quietCode_ff <= avsWriteData[3:0];
	end

	// Restart bit: write-1-to-set, hardware clear one clock later unless IDX_CTRL_TWO is written again
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ctrlTwo_ff <= RST_CTRL_TWO; // RL15
		else if (wrAcc && regIdx == IDX_CTRL_TWO)
		begin
			if (avsByteEnable[1])
				ctrlTwo_ff[C2_LOCK_VAL] <= avsWriteData[C2_LOCK_VAL];
			if (avsByteEnable[0])
			begin
				ctrlTwo_ff[C2_LOCK_FORCE:0] <= avsWriteData[C2_LOCK_FORCE:0];
				ctrlTwo_ff[C2_RESTART] <= avsWriteData[C2_RESTART]; // RL14
			end
		end
		else
			ctrlTwo_ff[C2_RESTART] <= 1'b0; // RL18
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			intMask_ff <= '0;
		else if (wrAcc && regIdx == IDX_INT_MASK && avsByteEnable[0])
			intMask_ff <= avsWriteData[INT_W-1:0];
	end

	// ****************************************
	// Hardware-set flags
	// ****************************************
	// Only bits that the captured read returned are cleared, so no event is lost
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pageRx_ff <= 1'b0;
		else
			pageRx_ff <= anPageIn |
				(pageRx_ff & ~(rdAcc && regIdx == IDX_STATUS && rdData_ff[ST_PAGE])); // RL10
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			fifoErr_ff <= 4'h0;
		else
			fifoErr_ff <= {rxFifoOverErr, rxFifoUnderErr, txFifoOverErr, txFifoUnderErr} |
				(fifoErr_ff & ~({4{rdAcc && regIdx == IDX_FIFO_ERR}} & rdData_ff[3:0])); // RL16
	end

	assign intEvents = {
		quietRun_ff && quietCnt_ff == '0 && !quietExp_ff,
		|{rxFifoOverErr, rxFifoUnderErr, txFifoOverErr, txFifoUnderErr},
		linkUpRaw != linkUp_ff,
		anComplete && !anDone_ff,
		anPageIn
	};

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			intStatus_ff <= '0;
		else
			intStatus_ff <= intEvents | (intStatus_ff &
				~({INT_W{rdAcc && regIdx == IDX_INT_STATUS}} & rdData_ff[INT_W-1:0]));
	end

	assign irq = |(intStatus_ff & intMask_ff);

	// ****************************************
	// Negotiation and link state
	// ****************************************
	smc_an_timer #(
		.AN_CYCLES0(AN_CYCLES0),
		.AN_CYCLES1(AN_CYC1),
		.AN_CYCLES2(AN_CYCLES2),
		.AN_CYCLES3(AN_CYCLES3)
	) smc_an_timer_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.anEnable(ctrlOne_ff[C1_AN_EN]),
		.anRestart(ctrlTwo_ff[C2_RESTART]),
		.timerSel(ctrlOne_ff[C1_AN_TMR_LO+:2]),
		.pageIn(anPageIn),
		.syncOk(wbSynced),
		.anComplete(anComplete)
	);

	assign linkUpRaw = ctrlOne_ff[C1_SGMII_EN] & wbSynced & cdrLock &
		(anComplete | ~ctrlOne_ff[C1_AN_EN]);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			linkUp_ff <= 1'b0;
			anDone_ff <= 1'b0;
			cdrLock <= 1'b0;
			alignIdx <= 4'h0;
		end
		else
		begin
			linkUp_ff <= linkUpRaw; // RL11
			anDone_ff <= anComplete; // RL11
			cdrLock <= ctrlTwo_ff[C2_LOCK_FORCE] ? ctrlTwo_ff[C2_LOCK_VAL] : cdrLockRaw; // RL13
			alignIdx <= ctrlOne_ff[C1_FORCE_EN] ? ctrlOne_ff[C1_IDX_LO+:4] : wbIdx; // RL4
		end
	end

	// ****************************************
	// Receive quiet timer
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst || !rxLpiActive)
		begin
			quietRun_ff <= 1'b0;
			quietCnt_ff <= '0;
			quietExp_ff <= 1'b0;
		end
		else if (!quietRun_ff)
		begin
			quietRun_ff <= 1'b1;
			quietCnt_ff <= quietLoad(quietCode_ff); // RL9
		end
		else if (quietCnt_ff != '0)
			quietCnt_ff <= quietCnt_ff - 1'b1;
		else
			quietExp_ff <= 1'b1;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sgmiiEnable = ctrlOne_ff[C1_SGMII_EN]; // RL1
	assign rxPolInvert = ctrlOne_ff[C1_RX_POL]; // RL5
	assign txPolInvert = ctrlOne_ff[C1_TX_POL]; // RL5
	assign rxLsbFirst = ctrlOne_ff[C1_RX_ORD]; // RL6
	assign txBitOrder = ctrlOne_ff[C1_TX_ORD_LO+:2];
	assign anEnable = ctrlOne_ff[C1_AN_EN]; // RL3
	assign anRestart = ctrlTwo_ff[C2_RESTART];
	assign serialLinkUp = linkUp_ff;
	assign eeeNonEeeMode = txTimers_ff[0]; // RL8
	assign txTrTimer = txTimers_ff[15:11];
	assign txTqTimer = txTimers_ff[10:6];
	assign txTsTimer = txTimers_ff[5:1];
	assign rxQuietExpired = quietExp_ff;
	assign txErrSuppress = ctrlOne_ff[C1_TXERR_DIS]; // RL17
	assign txFifoMidLevel = ctrlTwo_ff[C2_TX_MID_LO+:3]; // RL15
	assign rxFifoMidLevel = ctrlTwo_ff[C2_RX_MID_LO+:3]; // RL15
	assign txPktLaunch = txPktReady & (txEvenSlot | ~ctrlOne_ff[C1_ALIGN_PKT]); // RL7

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence restartWrite;
		wrAcc && regIdx == IDX_CTRL_TWO && avsByteEnable[0] && avsWriteData[C2_RESTART];
	endsequence
	sequence quietWrite;
		!(wrAcc && regIdx == IDX_CTRL_TWO);
	endsequence

	restart_pulse_a: assert property (restartWrite ##1 quietWrite |-> ##1 !anRestart) // RL18
		else $error("restart bit did not self clear");
	restart_set_a: assert property (restartWrite |=> anRestart) // RL14
		else $error("restart write did not set bit");
	page_flag_a: assert property (anPageIn |=> pageRx_ff) // RL10
		else $error("page flag not set by page event");
	pol_map_a: assert property (wrAcc && regIdx == IDX_CTRL_ONE && &avsByteEnable[1:0] |=> // RL5
		{rxPolInvert, txPolInvert} == $past(avsWriteData[8:7]))
		else $error("polarity outputs do not follow write");
	forced_idx_a: assert property (ctrlOne_ff[14] && $stable(ctrlOne_ff) |=> alignIdx == $past(ctrlOne_ff[13:10])) // RL4
		else $error("forced index not applied");
	lock_override_a: assert property (ctrlTwo_ff[7] |=> cdrLock == $past(ctrlTwo_ff[8])) // RL13
		else $error("lock override ignored");
	link_off_a: assert property (!sgmiiEnable |=> !serialLinkUp) // RL11
		else $error("link up while interface disabled");
	an_off_a: assert property (!anEnable ##1 !anEnable |-> !anComplete) // RL3
		else $error("negotiation complete while disabled");
	pkt_align_a: assert property (ctrlOne_ff[3] && txPktLaunch |-> txEvenSlot) // RL7
		else $error("packet launched off even slot");
	fifo_flag_a: assert property (rxFifoOverErr |=> fifoErr_ff[3]) // RL16
		else $error("rx overflow flag not set");
	bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
		else $error("bus answer later than one wait state");

endmodule

/* smc_mac_model.sv */
`timescale 1ns/1ps
module smc_mac_model import smc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Commands from the bench
	input wire logic pageReq,
	input wire logic [3:0] errReq,
	input wire logic syncOn,
	input wire logic lockOn,
	input wire logic lpiOn,
	input wire logic pktOn,
	input wire logic [3:0] idxSet,
	// Link side towards the block
	output logic wbAligned,
	output logic wbSynced,
	output logic [3:0] wbIdx,
	output logic cdrLockRaw,
	output logic anPageIn,
	output logic rxLpiActive,
	output logic rxFifoOverErr,
	output logic rxFifoUnderErr,
	output logic txFifoOverErr,
	output logic txFifoUnderErr,
	output logic txPktReady,
	output logic txEvenSlot
);
	// ****************************************
	// Far-side levels, one cycle behind the commands
	// ****************************************
	// Code slots alternate every cycle, so launch timing is never trivially aligned
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			{wbAligned, wbSynced, cdrLockRaw, anPageIn, rxLpiActive, txPktReady} <= 6'h00;
			{rxFifoOverErr, rxFifoUnderErr, txFifoOverErr, txFifoUnderErr} <= 4'h0;
			wbIdx <= 4'h0;
			txEvenSlot <= 1'b0;
		end
		else
		begin
			wbAligned <= syncOn;
			wbSynced <= syncOn;
			cdrLockRaw <= lockOn;
			anPageIn <= pageReq;
			rxLpiActive <= lpiOn;
			txPktReady <= pktOn;
			wbIdx <= idxSet;
			{rxFifoOverErr, rxFifoUnderErr, txFifoOverErr, txFifoUnderErr} <= errReq;
			txEvenSlot <= ~txEvenSlot;
		end
	end
endmodule

/* test_sgmii_mac_side_control.sv */
`timescale 1ns/1ps
module test_sgmii_mac_side_control import smc_pkg::*;;
	typedef struct {logic [31:0] exp; logic [31:0] msk;} smc_note_s;
	logic clk_sys, rst, avsRead, avsWrite, avsWaitRequest, pageReq, syncOn, lockOn, lpiOn, pktOn;
	logic [AV_AW-1:0] avsAddress;
	logic [31:0] avsWriteData, avsReadData, v;
	logic [3:0] avsByteEnable, errReq, idxSet, wbIdx, alignIdx;
	logic [2:0] rxDataStrap, txFifoMidLevel, rxFifoMidLevel;
	logic wbAligned, wbSynced, cdrLockRaw, anPageIn, rxLpiActive, txPktReady, txEvenSlot;
	logic rxFifoOverErr, rxFifoUnderErr, txFifoOverErr, txFifoUnderErr;
	logic sgmiiEnable, rxPolInvert, txPolInvert, rxLsbFirst, anEnable, anRestart, serialLinkUp;
	logic cdrLock, eeeNonEeeMode, rxQuietExpired, txErrSuppress, txPktLaunch, irq;
	logic [1:0] txBitOrder;
	logic [4:0] txTrTimer, txTqTimer, txTsTimer;
	int errorCnt = 0, testsRun = 0, n, k, seed;
	int anCyc[4] = '{20, 80, 10, 30};
	smc_note_s noteQ[$];
	smc_note_s note;

	smc_mac_model smc_mac_model_i (.clk_sys(clk_sys), .rst(rst), .pageReq(pageReq),
		.errReq(errReq), .syncOn(syncOn), .lockOn(lockOn), .lpiOn(lpiOn), .pktOn(pktOn),
		.idxSet(idxSet), .wbAligned(wbAligned), .wbSynced(wbSynced), .wbIdx(wbIdx),
		.cdrLockRaw(cdrLockRaw), .anPageIn(anPageIn), .rxLpiActive(rxLpiActive),
		.rxFifoOverErr(rxFifoOverErr), .rxFifoUnderErr(rxFifoUnderErr),
		.txFifoOverErr(txFifoOverErr), .txFifoUnderErr(txFifoUnderErr),
		.txPktReady(txPktReady), .txEvenSlot(txEvenSlot));

	// Short counts keep the negotiation and quiet timers within a quick run
	smc_mac_ctrl #(.AN_CYCLES0(20), .AN_CYCLES2(10), .AN_CYCLES3(30),
		.QUIET_BASE_CYCLES(50), .QUIET_STEP_CYCLES(5)) smc_mac_ctrl_i (
		.clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .rxDataStrap(rxDataStrap),
		.wbAligned(wbAligned), .wbSynced(wbSynced), .wbIdx(wbIdx), .cdrLockRaw(cdrLockRaw),
		.anPageIn(anPageIn), .rxLpiActive(rxLpiActive), .rxFifoOverErr(rxFifoOverErr),
		.rxFifoUnderErr(rxFifoUnderErr), .txFifoOverErr(txFifoOverErr),
		.txFifoUnderErr(txFifoUnderErr), .txPktReady(txPktReady), .txEvenSlot(txEvenSlot),
		.sgmiiEnable(sgmiiEnable), .rxPolInvert(rxPolInvert), .txPolInvert(txPolInvert),
		.rxLsbFirst(rxLsbFirst), .txBitOrder(txBitOrder), .alignIdx(alignIdx),
		.anEnable(anEnable), .anRestart(anRestart), .serialLinkUp(serialLinkUp),
		.cdrLock(cdrLock), .eeeNonEeeMode(eeeNonEeeMode), .txTrTimer(txTrTimer),
		.txTqTimer(txTqTimer), .txTsTimer(txTsTimer), .rxQuietExpired(rxQuietExpired),
		.txErrSuppress(txErrSuppress), .txFifoMidLevel(txFifoMidLevel),
		.rxFifoMidLevel(rxFifoMidLevel), .txPktLaunch(txPktLaunch), .irq(irq));

	// ****************************************
	// Clock, checking and closing
	// ****************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic testDone();
		$display("comparisons %0d, mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Read data is taken at the edge that samples waitrequest low
	always @(posedge clk_sys)
	begin
		if (avsRead === 1'b1 && avsWaitRequest === 1'b0 && noteQ.size() > 0)
		begin
			note = noteQ.pop_front();
			chkVal(avsReadData & note.msk, note.exp & note.msk);
		end
	end

	// ****************************************
	// Bus and stimulus helpers
	// ****************************************
	task automatic waitAck();
		int i;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk_sys);
			if (avsWaitRequest === 1'b0)
				break;
		end
		if (i == 50)
		begin
			errorCnt++;
			testDone();
		end
	endtask

	task automatic avRd(input logic [10:0] idx, input logic [31:0] exp, input logic [31:0] msk);
		@(posedge clk_sys);
		noteQ.push_back('{exp, msk});
		avsAddress <= {idx, 2'b00};
		avsRead <= 1'b1;
		waitAck();
		avsRead <= 1'b0;
	endtask

	task automatic avWr(input logic [10:0] idx, input logic [15:0] d);
		@(posedge clk_sys);
		avsAddress <= {idx, 2'b00};
		avsWriteData <= {16'h0000, d};
		avsByteEnable <= 4'hF;
		avsWrite <= 1'b1;
		waitAck();
		avsWrite <= 1'b0;
	endtask

	// Counts negedges until the chosen output rises; a lost event ends the run
	task automatic waitHigh(input bit quiet, output int cnt);
		for (cnt = 0; cnt < 2000; cnt++)
		begin
			@(negedge clk_sys);
			if ((quiet ? rxQuietExpired : serialLinkUp) === 1'b1)
				break;
		end
		if (cnt == 2000)
		begin
			errorCnt++;
			testDone();
		end
	endtask

	task automatic pulseCmd(input logic pg, input logic [3:0] er);
		@(posedge clk_sys);
		pageReq <= pg;
		errReq <= er;
		@(posedge clk_sys);
		pageReq <= 1'b0;
		errReq <= 4'h0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{avsRead, avsWrite, pageReq, syncOn, lockOn, lpiOn, pktOn} = 7'h00;
		avsAddress = '0;
		avsWriteData = '0;
		avsByteEnable = 4'hF;
		{errReq, idxSet} = 8'h00;
		rxDataStrap = 3'b000;
		rst = 1'b1;
		seed = $urandom(51);
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		avRd(IDX_CTRL_ONE, 32'h0000027B, '1);
		avRd(IDX_TX_TIMERS, 32'h0, '1);
		avRd(IDX_STATUS, 32'h0, '1);
		avRd(IDX_QUIET, 32'h5, '1);
		avRd(IDX_CTRL_TWO, 32'h24, '1);
		avRd(IDX_FIFO_ERR, 32'h0, '1);
		avRd(11'h700, 32'h0, '1);
		$display("reset values done");
		for (k = 0; k < 2; k++)
		begin
			idxSet <= 4'($urandom);
			v = {16'h0000, 16'($urandom)};
			v[14] = k[0];
			avWr(IDX_CTRL_ONE, v[15:0]);
			repeat (3) @(posedge clk_sys);
			chkVal({sgmiiEnable, rxPolInvert, txPolInvert, rxLsbFirst, txErrSuppress,
				anEnable, txBitOrder},
				{v[9], v[8], v[7], v[4], v[15], v[0], v[6:5]});
			chkVal(alignIdx, v[14] ? v[13:10] : idxSet);
			avRd(IDX_CTRL_ONE, v, '1);
		end
		v = 16'($urandom);
		avWr(IDX_TX_TIMERS, v[15:0]);
		avRd(IDX_TX_TIMERS, v, 32'hFFFF);
		chkVal({txTrTimer, txTqTimer, txTsTimer, eeeNonEeeMode}, v[15:0]);
		for (k = 0; k < 4; k++)
		begin
			v = 6'($urandom);
			lockOn <= 1'($urandom);
			avWr(IDX_CTRL_TWO, {7'h0, k[1], k[0], 1'b0, v[5:0]});
			repeat (3) @(posedge clk_sys);
			chkVal(cdrLock, k[0] ? k[1] : lockOn);
			chkVal({txFifoMidLevel, rxFifoMidLevel}, v[5:0]);
		end
		$display("control fields done");
		avWr(IDX_CTRL_TWO, 16'h0024);
		n = 0;
		repeat (6) @(negedge clk_sys) n += (anRestart === 1'b1);
		chkVal(n, 0);
		avWr(IDX_CTRL_TWO, 16'h0064);
		n = 0;
		repeat (6) @(negedge clk_sys) n += (anRestart === 1'b1);
		chkVal(n, 1);
		avRd(IDX_CTRL_TWO, 32'h24, '1);
		$display("restart done");
		syncOn <= 1'b1;
		lockOn <= 1'b1;
		for (k = 0; k < 4; k++)
		begin
			avWr(IDX_CTRL_ONE, 16'h0279 | 16'(k << 1));
			avWr(IDX_CTRL_TWO, 16'h0064);
			repeat (3) @(posedge clk_sys);
			chkVal(serialLinkUp, 1'b0);
			pulseCmd(1'b1, 4'h0);
			waitHigh(1'b0, n);
			chkVal(n >= anCyc[k] && n <= anCyc[k] + 4, 1'b1);
		end
		avRd(IDX_STATUS, {19'h0, 5'h1F, idxSet, 4'h0}, '1);
		avRd(IDX_STATUS, {19'h0, 5'h0F, idxSet, 4'h0}, '1);
		avWr(IDX_CTRL_TWO, 16'h0064);
		avWr(IDX_CTRL_ONE, 16'h0278);
		repeat (3) @(posedge clk_sys);
		chkVal(serialLinkUp, 1'b1);
		$display("negotiation done");
		v = 4'($urandom);
		avWr(IDX_QUIET, v[15:0]);
		lpiOn <= 1'b1;
		@(posedge clk_sys);
		waitHigh(1'b1, n);
		chkVal(n >= 50 + 5 * v && n <= 53 + 5 * v, 1'b1);
		lpiOn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chkVal(rxQuietExpired, 1'b0);
		$display("quiet timer done");
		avRd(IDX_INT_STATUS, 32'h17, 32'h1F);
		avWr(IDX_INT_MASK, 16'h0008);
		pulseCmd(1'b0, 4'hF);
		repeat (3) @(posedge clk_sys);
		chkVal(irq, 1'b1);
		avRd(IDX_FIFO_ERR, 32'hF, '1);
		avRd(IDX_FIFO_ERR, 32'h0, '1);
		avRd(IDX_INT_STATUS, 32'h8, 32'h8);
		repeat (2) @(posedge clk_sys);
		chkVal(irq, 1'b0);
		avWr(IDX_INT_MASK, 16'h0000);
		pulseCmd(1'b0, 4'h5);
		repeat (3) @(posedge clk_sys);
		chkVal(irq, 1'b0);
		avRd(IDX_FIFO_ERR, 32'h5, '1);
		$display("fifo flags and interrupt done");
		pktOn <= 1'b1;
		avWr(IDX_CTRL_ONE, 16'h027B);
		repeat (4) @(negedge clk_sys) chkVal(txPktLaunch, txEvenSlot);
		avWr(IDX_CTRL_ONE, 16'h0273);
		repeat (4) @(negedge clk_sys) chkVal(txPktLaunch, 1'b1);
		@(posedge clk_sys);
		rst <= 1'b1;
		rxDataStrap <= 3'b100;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		avRd(IDX_CTRL_ONE, 32'h0000007B, '1);
		$display("packet launch and strap done");
		testDone();
	end
endmodule
